// File: ocd_map.svh
// register map, field positions and reset values of the output pair divider
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH
// register indices; byte address is four times the index
`define OCD_IDX_PERIOD 10'h190
`define OCD_IDX_CONTROL 10'h191
`define OCD_IDX_ROUTING 10'h192
`define OCD_IDX_SRCSEL 10'h1e1
`define OCD_IDX_STATUS 10'h1f0
`define OCD_RST_PERIOD 8'h00
`define OCD_RST_CONTROL 8'h80
`define OCD_RST_ROUTING 8'h00
`define OCD_RST_SRCSEL 8'h00
// period fields
`define OCD_PER_LOW 7:4
`define OCD_PER_HIGH 3:0
// control fields
`define OCD_CTL_BYPASS 7
`define OCD_CTL_NOSYNC 6
`define OCD_CTL_FORCE 5
`define OCD_CTL_START 4
`define OCD_CTL_PHASE 3:0
// routing fields
`define OCD_RT_DIRECT 1
`define OCD_RT_DUTY_CORRECT_DISABLE 0
// source select field and codes
`define OCD_SRC_FIELD 1:0
`define OCD_SRC_OSC 2'b10
`define OCD_SRC_EXT 2'b00
`define OCD_SRC_NONE 2'b01
// bus constants
`define OCD_RESP_OKAY 2'h0
`define OCD_RESP_SLVERR 2'h2
`define OCD_PAD_W 24
`endif

// File: ocd_pkg.sv
// types shared by the output pair divider files
package ocd_pkg;
  // divider sequencing, gray coded along hold, delay, run
  typedef enum logic [1:0] {
    OCD_HOLD = 2'b00,
    OCD_DELAY = 2'b01,
    OCD_RUN = 2'b11
  } ocd_state_e;
  typedef logic [7:0] ocd_reg_t;
endpackage

// File: ocd_sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module ocd_sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin_lvl,
  output logic [W-1:0] sync_q
);
  logic [W-1:0] meta_q;
  genvar g;
  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= pin_lvl[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end
endmodule
`default_nettype wire

// File: ocd_div_core.sv
// high/low counting divider with start level, phase delay and duty correction
`timescale 1ns/1ps
`default_nettype none
module ocd_div_core #(
  parameter int CNT_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_rise,
  input wire logic hold,
  input wire logic start_high,
  input wire logic dcc_en,
  input wire logic [CNT_W-1:0] phase,
  input wire logic [CNT_W-1:0] high_cnt,
  input wire logic [CNT_W-1:0] low_cnt,
  output logic level_q,
  output ocd_pkg::ocd_state_e state_q
);
  import ocd_pkg::*;
  logic [CNT_W:0] sum, hi_lim, lo_lim, lim, cnt_q;
  logic [CNT_W-1:0] pcnt_q;

  ////////////////////////////////////////////////////////////////////////
  // correction splits the whole period evenly, odd periods favour high
  always_comb begin
    sum = {1'b0, high_cnt} + {1'b0, low_cnt};
    if (dcc_en) begin
      hi_lim = (sum + (CNT_W+1)'(1)) >> 1;
      lo_lim = sum - hi_lim;
    end else begin
      hi_lim = {1'b0, high_cnt};
      lo_lim = {1'b0, low_cnt};
    end
    lim = level_q ? hi_lim : lo_lim;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing; hold parks the output at the start level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= OCD_HOLD;
      level_q <= 1'b0;
      cnt_q <= '0;
      pcnt_q <= '0;
    end else if (hold) begin
      state_q <= OCD_HOLD;
      level_q <= start_high;
      cnt_q <= '0;
    end else begin
      case (state_q)
        OCD_HOLD: begin
          level_q <= start_high;
          pcnt_q <= phase;
          state_q <= (phase == '0) ? OCD_RUN : OCD_DELAY;
        end
        OCD_DELAY: begin
          if (src_rise) begin
            pcnt_q <= pcnt_q - CNT_W'(1);
            if (pcnt_q == CNT_W'(1)) begin
              state_q <= OCD_RUN;
            end
          end
        end
        OCD_RUN: begin
          // >= so that a period shortened mid-phase ends at once instead of wrapping
          if (src_rise && cnt_q >= lim) begin
            level_q <= ~level_q;
            cnt_q <= '0;
          end else if (src_rise) begin
            cnt_q <= cnt_q + (CNT_W+1)'(1);
          end
        end
        default: state_q <= OCD_HOLD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LOW_LEN: assert property (!hold && state_q == OCD_RUN && !level_q && src_rise
    && cnt_q == lo_lim |=> level_q) else $error("low phase did not end on count");
  AST_HIGH_LEN: assert property (!hold && state_q == OCD_RUN && level_q && src_rise
    && cnt_q < hi_lim |=> level_q) else $error("high phase ended early");
  AST_DCC_SPLIT: assert property (dcc_en |-> hi_lim + lo_lim == sum
    && hi_lim >= lo_lim && hi_lim - lo_lim <= 1) else $error("duty split uneven");
  AST_PHASE_WAIT: assert property (!hold && state_q == OCD_HOLD && phase != '0
    |=> state_q == OCD_DELAY && pcnt_q == $past(phase)) else $error("phase delay skipped");
endmodule
`default_nettype wire

// File: ocd_top.sv
// output pair clock divider with routing and an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ocd_map.svh"
// Overview of operation
// - with the correction-disable bit set, the divider output stays low for the low-count field plus one input cycles, reset zero.
// - with the correction-disable bit set, the divider output stays high for the high-count field plus one input cycles, reset zero.
// - with bypass set the divider is powered down and its input passes straight through.
// - with ignore-sync clear the divider obeys the chip sync signal, with it set it ignores it.
// - with ignore-sync set and direct-route and bypass clear, the output sits static at the level of the force-high bit.
// - the start-level bit picks whether the divided clock starts low or high.
// - a four-bit phase-offset field, reset zero, sets the coarse phase of the divider.
// - with direct-route, bypass and ignore-sync all clear, both pair outputs follow the divider output.
// - direct-route with source select 10 sends the internal oscillator to both outputs.
// - direct-route with source select 00 sends the external clock input to both outputs.
// - direct-route with source select 01 has no effect and the divider path stays.
// - duty-cycle correction is on while the correction-disable bit is clear.
module ocd_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic internal_oscillator,
  input wire logic ext_clk_in,
  input wire logic sync_n,
  output logic pair_a_output_first,
  output logic pair_a_output_second
);
  import ocd_pkg::*;

  ocd_reg_t period_q, control_q, routing_q, srcsel_q;
  logic aw_have_q, w_have_q, w_lane_q, wr_fire, wr_hit, rd_hit;
  logic [ADDR_W-3:0] aw_idx_q, ar_idx;
  logic [7:0] w_byte_q;
  ocd_reg_t rd_val;
  logic [2:0] pin_s;
  logic osc_s, ext_s, sync_act, src_lvl, src_prev_q, src_rise;
  logic bypass, nosync, force_hi, direct, dcc_en, hold, out_d;
  logic [1:0] src_sel;
  logic div_level;
  ocd_state_e div_state;

  ////////////////////////////////////////////////////////////////////////
  // pins are asynchronous to aclk; nothing reads them before two flops
  ocd_sync2 #(.W(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_lvl({sync_n, ext_clk_in, internal_oscillator}),
    .sync_q(pin_s)
  );
  assign osc_s = pin_s[0];
  assign ext_s = pin_s[1];
  assign sync_act = ~pin_s[2];

  ////////////////////////////////////////////////////////////////////////
  // field decode
  assign bypass = control_q[`OCD_CTL_BYPASS];
  assign nosync = control_q[`OCD_CTL_NOSYNC];
  assign force_hi = control_q[`OCD_CTL_FORCE];
  assign direct = routing_q[`OCD_RT_DIRECT];
  assign dcc_en = ~routing_q[`OCD_RT_DUTY_CORRECT_DISABLE];
  assign src_sel = srcsel_q[`OCD_SRC_FIELD];
  // the divider input is the oscillator only when selected, else the pin
  assign src_lvl = (src_sel == `OCD_SRC_OSC) ? osc_s : ext_s;
  // a powered-down divider and a sync it obeys both park the counter
  assign hold = bypass | (sync_act & ~nosync);

  ////////////////////////////////////////////////////////////////////////
  // rising edges of the divider input; src_lvl is already second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end
  assign src_rise = src_lvl & ~src_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // divider proper; the input must toggle below half the aclk rate
  ocd_div_core #(.CNT_W(4)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_rise(src_rise),
    .hold(hold),
    .start_high(control_q[`OCD_CTL_START]),
    .dcc_en(dcc_en),
    .phase(control_q[`OCD_CTL_PHASE]),
    .high_cnt(period_q[`OCD_PER_HIGH]),
    .low_cnt(period_q[`OCD_PER_LOW]),
    .level_q(div_level),
    .state_q(div_state)
  );

  ////////////////////////////////////////////////////////////////////////
  // output selection: direct route first, then bypass, force, divider
  always_comb begin
    if (direct && src_sel == `OCD_SRC_OSC) begin
      out_d = osc_s;
    end else if (direct && src_sel == `OCD_SRC_EXT) begin
      out_d = ext_s;
    end else if (bypass) begin
      out_d = src_lvl;
    end else if (nosync) begin
      out_d = force_hi;
    end else begin
      out_d = div_level;
    end
  end

  // both outputs of the pair come from one decision so they never skew
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_a_output_first <= 1'b0;
      pair_a_output_second <= 1'b0;
    end else begin
      pair_a_output_first <= out_d;
      pair_a_output_second <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write address channel; ready drops once an address is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_have_q <= 1'b0;
      aw_idx_q <= '0;
    end else if (awready && awvalid) begin
      awready <= 1'b0;
      aw_have_q <= 1'b1;
      aw_idx_q <= awaddr[ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid) begin
      awready <= 1'b1;
    end
  end

  // write data channel; only byte lane zero carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_have_q <= 1'b0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
    end else if (wready && wvalid) begin
      wready <= 1'b0;
      w_have_q <= 1'b1;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid) begin
      wready <= 1'b1;
    end
  end

  assign wr_fire = aw_have_q & w_have_q & ~bvalid;

  // write decode; status is read only and unmapped words answer slverr
  always_comb begin
    case (aw_idx_q)
      `OCD_IDX_PERIOD, `OCD_IDX_CONTROL, `OCD_IDX_ROUTING, `OCD_IDX_SRCSEL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `OCD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `OCD_RESP_OKAY : `OCD_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers; a cleared lane-zero strobe leaves them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= `OCD_RST_PERIOD;
      control_q <= `OCD_RST_CONTROL;
      routing_q <= `OCD_RST_ROUTING;
      srcsel_q <= `OCD_RST_SRCSEL;
    end else if (wr_fire && w_lane_q) begin
      case (aw_idx_q)
        `OCD_IDX_PERIOD: period_q <= w_byte_q;
        `OCD_IDX_CONTROL: control_q <= w_byte_q;
        `OCD_IDX_ROUTING: routing_q <= w_byte_q;
        `OCD_IDX_SRCSEL: srcsel_q <= w_byte_q;
        default: period_q <= period_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode; status shows the divider's live state
  assign ar_idx = araddr[ADDR_W-1:2];
  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      `OCD_IDX_PERIOD: rd_val = period_q;
      `OCD_IDX_CONTROL: rd_val = control_q;
      `OCD_IDX_ROUTING: rd_val = routing_q;
      `OCD_IDX_SRCSEL: rd_val = srcsel_q;
      `OCD_IDX_STATUS: rd_val = {3'h0, pair_a_output_first, div_state, sync_act, div_level};
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel; data is captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `OCD_RESP_OKAY;
    end else if (arready && arvalid) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {{`OCD_PAD_W{1'b0}}, rd_val};
      rresp <= rd_hit ? `OCD_RESP_OKAY : `OCD_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid && !arready) begin
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on routing, sync handling, register writes and read answers
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BYPASS_PASS: assert property (!direct && bypass
    |=> pair_a_output_first == $past(src_lvl) && div_state == OCD_HOLD)
    else $error("bypass did not pass the input through");

  AST_SYNC_HOLD: assert property (!nosync && sync_act && !bypass
    |=> div_state == OCD_HOLD && div_level == $past(control_q[`OCD_CTL_START]))
    else $error("sync did not park the divider at its start level");

  AST_NOSYNC_RUN: assert property (nosync && !bypass && div_state == OCD_RUN
    |=> div_state == OCD_RUN) else $error("ignored sync still stopped the divider");

  AST_FORCE_LEVEL: assert property (!direct && !bypass && nosync
    |=> pair_a_output_first == $past(force_hi)) else $error("forced level wrong");

  AST_DIV_ROUTE: assert property (!direct && !bypass && !nosync
    |=> pair_a_output_first == $past(div_level) && pair_a_output_second == $past(div_level))
    else $error("pair outputs do not follow the divider");

  AST_DIRECT_OSC: assert property (direct && src_sel == `OCD_SRC_OSC
    |=> pair_a_output_first == $past(osc_s)) else $error("oscillator not routed");

  AST_DIRECT_EXT: assert property (direct && src_sel == `OCD_SRC_EXT
    |=> pair_a_output_second == $past(ext_s)) else $error("external clock not routed");

  AST_DIRECT_NONE: assert property (direct && src_sel == `OCD_SRC_NONE
    && !bypass && !nosync |=> pair_a_output_first == $past(div_level))
    else $error("direct route with no source changed the outputs");

  AST_WR_PERIOD: assert property (wr_fire && w_lane_q && aw_idx_q == `OCD_IDX_PERIOD
    |=> period_q == $past(w_byte_q) && bvalid) else $error("period write lost");

  AST_WR_ROUTING: assert property (wr_fire && w_lane_q && aw_idx_q == `OCD_IDX_ROUTING
    |=> dcc_en == !$past(w_byte_q[`OCD_RT_DUTY_CORRECT_DISABLE])) else $error("correction bit not applied");

  AST_PHASE_FIELD: assert property (wr_fire && w_lane_q && aw_idx_q == `OCD_IDX_CONTROL
    |=> control_q[`OCD_CTL_PHASE] == $past(w_byte_q[3:0])) else $error("phase write lost");

  AST_RD_ANSWER: assert property (arready && arvalid
    |=> rvalid && !arready) else $error("read not answered next cycle");
endmodule
`default_nettype wire

// File: ocd_src_model.sv
// clock source model on the far side: oscillator and external clock pins
`timescale 1ns/1ps
`default_nettype none
module ocd_src_model #(
  parameter int HP_EXT = 4,
  parameter int HP_OSC = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic osc,
  output logic ext,
  output logic ext_wrap
);
  int ce_q;
  int co_q;
  // free running phase counters; both stay slower than aclk/2 as the divider needs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ce_q <= 0;
      co_q <= 0;
    end else begin
      ce_q <= (ce_q == 2 * HP_EXT - 1) ? 0 : ce_q + 1;
      co_q <= (co_q == 2 * HP_OSC - 1) ? 0 : co_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pin levels, plus a marker used to align sync release to a source edge
  assign ext = (ce_q >= HP_EXT);
  assign osc = (co_q >= HP_OSC);
  assign ext_wrap = (ce_q == 0);
endmodule
`default_nettype wire

// File: ocd_top_tb_top.sv
// self-checking bench of the output pair divider
`timescale 1ns/1ps
`default_nettype none
`include "ocd_map.svh"
module ocd_top_tb_top;
  localparam int HPE = 4;
  localparam int HPO = 3;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sync_n;
  logic awready, wready, bvalid, arready, rvalid, o1, o2, osc, ext, ext_wrap;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [31:0] rng;
  int fail_count, checks, hi, lo, t0, t3, h, l;
  ocd_top ocd_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .internal_oscillator(osc), .ext_clk_in(ext), .sync_n(sync_n),
    .pair_a_output_first(o1), .pair_a_output_second(o2));
  ocd_src_model #(.HP_EXT(HPE), .HP_OSC(HPO)) ocd_src_model_inst (.aclk(aclk),
    .aresetn(aresetn), .osc(osc), .ext(ext), .ext_wrap(ext_wrap));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // bus master: payload held until its own ready, response ready held until valid
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // run lengths of the pair output, taken on the second full period so changes settle
  task automatic measure(output int hi, output int lo);
    int n;
    n = 0;
    repeat (2) begin
      hi = 0;
      lo = 0;
      while (o1 !== 1'b0 && n < 2000) begin @(posedge aclk); n++; end
      while (o1 !== 1'b1 && n < 2000) begin @(posedge aclk); n++; end
      while (o1 === 1'b1 && n < 2000) begin @(posedge aclk); n++; hi++; check(o2, o1); end
      while (o1 === 1'b0 && n < 2000) begin @(posedge aclk); n++; lo++; end
    end
  endtask
  // count cycles where the output leaves the static level
  task automatic stat(input logic e, output int bad);
    bad = 0;
    // the new setting reaches the pair output register two edges after the write answer
    repeat (2) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      if (o1 !== e || o2 !== e) bad++;
    end
  endtask
  // time from an edge-aligned sync release to the first rising output edge
  task automatic release_time(output int t);
    int n;
    @(posedge aclk);
    sync_n <= 1'b0;
    repeat (10) @(posedge aclk);
    n = 0;
    while (ext_wrap !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
    sync_n <= 1'b1;
    t = 0;
    while (o1 !== 1'b1 && t < 1000) begin @(posedge aclk); t++; end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    sync_n = 1'b1;
    rng = 32'h76cd;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and the read-only and unmapped places
    rd(`OCD_IDX_PERIOD, rv, rs); check(rv, `OCD_RST_PERIOD);
    rd(`OCD_IDX_CONTROL, rv, rs); check(rv, `OCD_RST_CONTROL);
    rd(`OCD_IDX_ROUTING, rv, rs); check(rv, `OCD_RST_ROUTING);
    rd(10'h000, rv, rs); check(rv, 32'h0);
    check({30'h0, rs}, {30'h0, `OCD_RESP_SLVERR});
    wr(`OCD_IDX_STATUS, 8'hff, `OCD_RESP_SLVERR);
    // bypass passes the external clock straight through
    measure(hi, lo); check(hi, HPE); check(lo, HPE);
    wr(`OCD_IDX_ROUTING, 8'h01, `OCD_RESP_OKAY);
    wr(`OCD_IDX_CONTROL, 8'h00, `OCD_RESP_OKAY);
    rd(`OCD_IDX_CONTROL, rv, rs); check(rv, 32'h0);
    // raw counts, boundary case first, then random ones
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      h = (i == 0) ? 15 : rng[1:0];
      l = (i == 0) ? 0 : rng[5:4];
      wr(`OCD_IDX_PERIOD, {l[3:0], h[3:0]}, `OCD_RESP_OKAY);
      measure(hi, lo);
      check(hi, (h + 1) * 2 * HPE);
      check(lo, (l + 1) * 2 * HPE);
    end
    // correction on: period of 5 source cycles split 3 high, 2 low
    wr(`OCD_IDX_PERIOD, 8'h03, `OCD_RESP_OKAY);
    wr(`OCD_IDX_ROUTING, 8'h00, `OCD_RESP_OKAY);
    measure(hi, lo); check(hi, 3 * 2 * HPE); check(lo, 2 * 2 * HPE);
    // ignore-sync with force high and force low, sync asserted meanwhile
    wr(`OCD_IDX_CONTROL, 8'h60, `OCD_RESP_OKAY);
    sync_n <= 1'b0;
    stat(1'b1, hi); check(hi, 0);
    wr(`OCD_IDX_CONTROL, 8'h40, `OCD_RESP_OKAY);
    stat(1'b0, hi); check(hi, 0);
    // sync held parks the divider at the start level
    wr(`OCD_IDX_CONTROL, 8'h10, `OCD_RESP_OKAY);
    stat(1'b1, hi); check(hi, 0);
    wr(`OCD_IDX_CONTROL, 8'h00, `OCD_RESP_OKAY);
    stat(1'b0, hi); check(hi, 0);
    sync_n <= 1'b1;
    // direct routes per source code; code 01 leaves the forced divider path
    wr(`OCD_IDX_ROUTING, 8'h02, `OCD_RESP_OKAY);
    wr(`OCD_IDX_SRCSEL, {6'h0, `OCD_SRC_OSC}, `OCD_RESP_OKAY);
    measure(hi, lo); check(hi, HPO); check(lo, HPO);
    wr(`OCD_IDX_SRCSEL, {6'h0, `OCD_SRC_EXT}, `OCD_RESP_OKAY);
    measure(hi, lo); check(hi, HPE); check(lo, HPE);
    wr(`OCD_IDX_CONTROL, 8'h60, `OCD_RESP_OKAY);
    wr(`OCD_IDX_SRCSEL, {6'h0, `OCD_SRC_NONE}, `OCD_RESP_OKAY);
    stat(1'b1, hi); check(hi, 0);
    // phase offset delays the first edge by that many source cycles
    wr(`OCD_IDX_ROUTING, 8'h01, `OCD_RESP_OKAY);
    wr(`OCD_IDX_PERIOD, 8'h00, `OCD_RESP_OKAY);
    wr(`OCD_IDX_CONTROL, 8'h00, `OCD_RESP_OKAY);
    release_time(t0);
    wr(`OCD_IDX_CONTROL, 8'h03, `OCD_RESP_OKAY);
    release_time(t3);
    check(t3 - t0, 3 * 2 * HPE);
    tally_and_finish();
  end
endmodule
`default_nettype wire
